// *** bench/spx_exception_logic_properties.sv ***
// spx_exception_logic_properties.sv: port checks of the spi exception logic
// assumes binding to spx_exception_logic; status output lags its flags one clock
`timescale 1ns/1ps
`default_nettype none
`include "spx_defines.vh"
module spx_exception_logic_properties (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_cs_n,
   input wire logic o_miso,
   input wire logic o_miso_oe,
   input wire logic [4:0] o_reg_addr,
   input wire logic o_wr_strobe,
   input wire logic o_arm_update,
   input wire logic o_pcm_enable,
   input wire logic [7:0] o_device_status_register
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // frame edges and the driver window
   a_oe_start: assert property ($fell(i_cs_n) |-> ##[2:6] o_miso_oe) else $error("miso not driven");
   a_oe_end: assert property ($rose(i_cs_n) |-> ##[2:6] !o_miso_oe) else $error("miso still driven");
   a_miso_idle: assert property (!o_miso_oe && $past(!o_miso_oe) |-> !o_miso) else $error("miso idle high");
   // writes and arming only between frames, one clock long
   a_wr_pulse: assert property (o_wr_strobe |-> !o_miso_oe && i_cs_n ##1 !o_wr_strobe) else $error("bad write");
   a_arm_pulse: assert property (o_arm_update |-> !o_miso_oe ##1 !o_arm_update) else $error("bad arm");
   // pulse code output off under reset indications
   a_pcm_off: assert property (o_device_status_register[2:1] != 2'h0 && $past(o_device_status_register[2:1]) != 2'h0
      |-> !$past(o_pcm_enable)) else $error("pcm on");
   // mismatch and reset flags clear only by a status read
   a_mism_clear: assert property ($fell(o_device_status_register[0]) |-> o_reg_addr == `SPX_ADDR_STAT && i_cs_n)
      else $error("mismatch cleared");
   a_res_clear: assert property ($fell(o_device_status_register[2]) |-> o_reg_addr == `SPX_ADDR_STAT)
      else $error("reset flag cleared");
endmodule // spx_exception_logic_properties
`default_nettype wire

// *** bench/spx_exception_logic_tb.sv ***
// spx_exception_logic_tb.sv: self-checking bench of the spi exception logic
// assumes spx_spi_master as far side; each answer is checked one frame later
`timescale 1ns/1ps
`default_nettype none
module spx_exception_logic_tb;
   logic clk = 1'b0, rst_n = 1'b0, flip = 1'b0, done = 1'b0, lock = 1'b0, otp = 1'b0, st = 1'b0, ofx = 1'b0;
   logic [1:0] cfg = 2'h1;
   logic [9:0] ax = 10'h2A5, ay = 10'h15A;
   logic [15:0] r, pe = 16'hF000, pm = 16'hF000;
   wire cs_n, sclk, mosi, miso, oe, wr_s, arm, axis, pcm;
   wire [4:0] addr;
   wire [7:0] wd, stat;
   int n_mismatch = 0, num_checks = 0, n_arm = 0, n_wr = 0, cyc = 0;
   initial forever #25 clk = ~clk;
   spx_spi_master spx_spi_master_inst (.i_clk_sys(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
   spx_exception_logic spx_exception_logic_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_mosi(mosi), .i_miso_rb(miso ^ flip), .i_init_done(done), .i_config_lock_flag(lock), .i_cfg_bits(cfg),
      .i_otp_crc_fail(otp), .i_wreg_crc_fail(1'b0), .i_selftest_fail(st), .i_logic_fault(1'b0), .i_ofs_ovr_x(ofx),
      .i_ofs_ovr_y(1'b0), .i_modulator_ovr(1'b0), .i_accel_x(ax), .i_accel_y(ay),
      .i_reg_rdata(addr == 5'h14 ? stat : 8'h5A), .o_miso(miso), .o_miso_oe(oe), .o_reg_addr(addr),
      .o_wr_strobe(wr_s), .o_wr_data(wd), .o_arm_update(arm), .o_arm_axis(axis), .o_pcm_enable(pcm),
      .o_device_status_register(stat));
   // count pulses, cut a hang short
   always @(posedge clk) begin
      n_arm += arm;
      n_wr += wr_s;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // odd parity in bit 0 of accel requests, bit 15 of register requests
   function automatic logic [15:0] mk(input logic [15:0] c);
      if (c[14]) c[0] = ~^c[15:1];
      else c[15] = ~^c[14:0];
      return c;
   endfunction
   function automatic logic [15:0] acc(input logic y, input logic [1:0] g);
      return mk({2'b01, y, 10'h000, g, 1'b0});
   endfunction
   function automatic logic [15:0] rd(input logic [4:0] a);
      return mk({3'b000, a, 8'h00});
   endfunction
   function automatic logic [15:0] wr(input logic [4:0] a, input logic [7:0] d);
      return mk({3'b001, a, d});
   endfunction
   // send a frame, check the answer of the previous one, keep this expectation
   task automatic s(input logic [15:0] c, e, m, input int nr = 16, input logic f = 1'b0);
      flip = f;
      spx_spi_master_inst.xfer(c, nr, r);
      flip = 1'b0;
      chk(r & pm, pe & pm);
      pe = e;
      pm = m;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
      s(acc(1'b0, cfg), 16'hB000, 16'hF000);
      chk(16'(pcm), 16'h0000);
      done = 1'b1;
      s(rd(5'h14), 16'h3004, 16'hF0FF);
      s(acc(1'b0, cfg), 16'h12A5, 16'hFFFF);
      s(acc(1'b1, cfg), 16'h115A, 16'hFFFF);
      chk(16'(pcm), 16'h0001);
      chk(16'(axis), 16'h0001);
      $display("reset test done");
      s(acc(1'b0, cfg) ^ 16'h0001, 16'hF000, 16'hF000);
      s(mk(16'hC002), 16'hF000, 16'hF000);
      s(mk(acc(1'b0, cfg) | 16'h0040), 16'hF000, 16'hF000);
      s(mk(16'h1401), 16'hF000, 16'hF000);
      s(acc(1'b0, cfg), 16'hF000, 16'hF000, 15);
      s(wr(5'h01, 8'h33) ^ 16'h8000, 16'hF000, 16'hF000);
      chk(n_arm[15:0], 16'h0002);
      chk(n_wr[15:0], 16'h0000);
      chk(16'(pcm), 16'h0001);
      $display("error test done");
      lock = 1'b1;
      s(acc(1'b0, 2'h2), 16'hD000, 16'hF000);
      s(wr(5'h14, 8'h00), 16'hC000, 16'hF000);
      s(rd(5'h15), 16'hC000, 16'hF000);
      s(wr(5'h01, 8'h55), 16'hC000, 16'hF000);
      s(wr(5'h10, 8'h5A), 16'h2000, 16'hF000);
      chk({8'h00, wd}, 16'h005A);
      lock = 1'b0;
      $display("invalid test done");
      s(acc(1'b0, cfg), 16'hE000, 16'hF000, 16, 1'b1);
      s(rd(5'h14), 16'hE000, 16'hF000, 16, 1'b1);
      chk(16'(stat[0]), 16'h0001);
      s(wr(5'h02, 8'h33), 16'hE000, 16'hF000, 16, 1'b1);
      chk({8'h00, wd}, 16'h0033);
      s(rd(5'h14), 16'h3001, 16'hF0FF);
      chk(16'(stat[0]), 16'h0000);
      chk(n_arm[15:0], 16'h0002);
      chk(n_wr[15:0], 16'h0002);
      $display("mismatch test done");
      st = 1'b1;
      s(acc(1'b0, cfg), 16'hA000, 16'hF000);
      st = 1'b0;
      s(acc(1'b0, cfg), 16'hA000, 16'hF000);
      s(rd(5'h14), 16'h3088, 16'hF0FF);
      s(acc(1'b0, cfg), 16'h12A5, 16'hFFFF);
      ofx = 1'b1;
      s(acc(1'b0, cfg), 16'h1AA5, 16'hFFFF);
      ofx = 1'b0;
      s(acc(1'b0, cfg), 16'h1AA5, 16'hFFFF);
      s(acc(1'b0, cfg), 16'h12A5, 16'hFFFF);
      chk(16'(stat[4]), 16'h0001);
      s(rd(5'h14), 16'h3010, 16'hF0FF);
      chk(n_arm[15:0], 16'h0006);
      otp = 1'b1;
      s(acc(1'b0, cfg), 16'hB000, 16'hF000);
      s(rd(5'h14), 16'h3008, 16'hF0FF);
      s(rd(5'h14), 16'h0000, 16'h0000);
      chk(16'(stat[3]), 16'h0001);
      chk(16'(pcm), 16'h0001);
      chk(n_arm[15:0], 16'h0006);
      $display("internal test done");
      report_and_stop;
   end
endmodule // spx_exception_logic_tb
bind spx_exception_logic spx_exception_logic_properties spx_exception_logic_properties_inst (.i_clk_sys, .i_arst_n,
   .i_cs_n, .o_miso, .o_miso_oe, .o_reg_addr, .o_wr_strobe, .o_arm_update, .o_pcm_enable, .o_device_status_register);
`default_nettype wire

// *** bench/spx_spi_master.sv ***
// spx_spi_master.sv: behavioural spi master, mode 0, msb first
// assumes a 50 ns system clock; sclk half period is four clocks
`timescale 1ns/1ps
`default_nettype none
module spx_spi_master (
   input wire logic i_clk_sys,
   input wire logic i_miso,
   output var logic o_cs_n,
   output var logic o_sclk,
   output var logic o_mosi
);
   // idle levels
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // one frame of nr rising edges, answer bits taken late in each high phase
   task automatic xfer(input logic [15:0] c, input int nr, output logic [15:0] r);
      r = 16'h0000;
      @(negedge i_clk_sys) o_cs_n = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      for (int i = 15; i > 15 - nr; i--) begin
         o_mosi = c[i];
         repeat (4) @(negedge i_clk_sys);
         o_sclk = 1'b1;
         repeat (4) @(negedge i_clk_sys);
         r[i] = i_miso;
         o_sclk = 1'b0;
      end
      repeat (4) @(negedge i_clk_sys);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi; // released line shows no stale bit
      repeat (12) @(negedge i_clk_sys);
   endtask
endmodule // spx_spi_master
`default_nettype wire

// *** src/spx_defines.vh ***
// spx_defines.vh: constants of the spi exception and response logic
// assumes inclusion by bare name from the design file; definitions only
`ifndef SPX_DEFINES_VH
`define SPX_DEFINES_VH

// frame layout
`define SPX_FRAME_BITS 5'd16
`define SPX_CNT_MAX 5'h1F
`define SPX_B_TOP 15
`define SPX_B_ACC 14
`define SPX_B_AX 13
`define SPX_B_AHI 12
`define SPX_B_ALO 8
`define SPX_B_CFGHI 2
`define SPX_B_CFGLO 1

// register addresses
`define SPX_ADDR_STAT 5'h14
`define SPX_ADDR_CTL 5'h10

// response codes, bits 15:12 of the response word
`define SPX_RSP_ACC_OK 4'h1
`define SPX_RSP_WR_OK 4'h2
`define SPX_RSP_RD_OK 4'h3
`define SPX_RSP_SPI_ERR 4'hF
`define SPX_RSP_MISO_ERR 4'hE
`define SPX_RSP_INV_ACC 4'hD
`define SPX_RSP_INV_REG 4'hC
`define SPX_RSP_INT_ERR 4'hB
`define SPX_RSP_INV_DATA 4'hB
`define SPX_RSP_ST_ERR 4'hA

// accel status field values
`define SPX_ST_NORMAL 2'h0
`define SPX_ST_OVR 2'h2

// device status register bit positions
`define SPX_S_MISM 0
`define SPX_S_INIT 1
`define SPX_S_RES 2
`define SPX_S_IDE 3
`define SPX_S_OFSX 4
`define SPX_S_OFSY 5
`define SPX_S_MOD 6
`define SPX_S_ST 7

`endif

// *** src/spx_exception_logic.v ***
// spx_exception_logic.v: spi slave frame checking, exception priority and response selection
// assumes pins arrive asynchronously to i_clk_sys and the link clock is far slower than it
//
// Contract
// - spi error if rising sclk count per frame is not 16 or sclk high at start
// - spi error if sclk is high when chip select is released
// - any command parity failure is a spi error
// - spi error on accel bit 15 or bits 3..11 set, or read bits 0..7 set
// - any spi error answers with the spi error code next frame
// - spi error leaves arming unchanged, pulse code output keeps running
// - every driven output bit is read back; a mismatch sets the mismatch flag
// - accel request in a mismatch frame is dropped, no arming, miso error next
// - register write in a mismatch frame is done but answered with miso error
// - register read in a mismatch frame is dropped, miso error, no clear on read
// - mismatch flag holds until a good read of the device status register
// - accel config disagreement answers invalid accel once, no fault, no arming
// - invalid register answer on unreadable, unwritable, or locked writes except control
// - init or reset flags: internal error answer, no arming, pulse code disabled
// - init flag clears when initialization ends; reset flag clears on status read
// - internal error flag set by otp crc, register crc, self-test or logic fault
// - crc internal error: internal error answer, no arming, registers still work
// - register crc error after lock clears only by reset; otp crc error never clears
// - self-test failure answers self-test error, held until status read if gone
// - offset over-range: valid data status 10, arming kept, one extra 10 after
// - modulator over-range: valid data status 10, arming kept, one extra 10 after
// - first output after reset is spi error; accel answered invalid until reset flag cleared
// - mode 0 msb first, pins ignored while chip select released
// - command parity is odd over all sixteen bits
// - each answer goes out in the frame after its command
// - register write only after the frame ends, dropped on spi error
`timescale 1ns/1ps
`default_nettype none
`include "spx_defines.vh"

module spx_exception_logic #(
   parameter [31:0] READABLE_MASK = 32'h0010FFFF,
   parameter [31:0] WRITABLE_MASK = 32'h0001FFFF
) (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_mosi,
   input wire i_miso_rb,
   input wire i_init_done,
   input wire i_config_lock_flag,
   input wire [1:0] i_cfg_bits,
   input wire i_otp_crc_fail,
   input wire i_wreg_crc_fail,
   input wire i_selftest_fail,
   input wire i_logic_fault,
   input wire i_ofs_ovr_x,
   input wire i_ofs_ovr_y,
   input wire i_modulator_ovr,
   input wire [9:0] i_accel_x,
   input wire [9:0] i_accel_y,
   input wire [7:0] i_reg_rdata,
   output reg o_miso,
   output reg o_miso_oe,
   output reg [4:0] o_reg_addr,
   output reg o_wr_strobe,
   output reg [7:0] o_wr_data,
   output reg o_arm_update,
   output reg o_arm_axis,
   output reg o_pcm_enable,
   output reg [7:0] o_device_status_register
);

   // odd parity check over a frame
   function parity_ok;
      input [15:0] w;
      begin
         parity_ok = ^w;
      end
   endfunction

   // synchroniser stages: a, b, c per pin
   reg [3:0] sync_a;
   reg [3:0] sync_b;
   reg [3:0] sync_c;
   reg [3:0] filt;
   reg [3:0] filt_q;
   wire cs_n_f = filt[0];
   wire sclk_f = filt[1];
   wire mosi_f = filt[2];
   wire rb_f = filt[3];
   wire cs_fall = filt_q[0] & ~cs_n_f;
   wire cs_rise = ~filt_q[0] & cs_n_f;
   wire sclk_rise = ~filt_q[1] & sclk_f;
   wire sclk_fall = filt_q[1] & ~sclk_f;

   // three stage sync, a change counts once stages b and c agree
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync_a <= 4'h1;
         sync_b <= 4'h1;
         sync_c <= 4'h1;
         filt <= 4'h1;
         filt_q <= 4'h1;
      end else begin
         sync_a <= {i_miso_rb, i_mosi, i_sclk, i_cs_n};
         sync_b <= sync_a;
         sync_c <= sync_b;
         filt <= (sync_c & ~(sync_b ^ sync_c)) | (filt & (sync_b ^ sync_c));
         filt_q <= filt;
      end
   end

   reg in_frame;
   reg [4:0] edge_cnt;
   reg [15:0] rx;
   reg [15:0] tx;
   reg start_err;
   reg frame_mism;

   // sticky state
   reg mism_flag;
   reg init_pending;
   reg reset_occurred;
   reg otp_err;
   reg wreg_err;
   reg st_err;
   reg logic_err;
   reg ofsx_flag;
   reg ofsy_flag;
   reg mod_flag;
   reg ofsx_hold;
   reg ofsy_hold;
   reg mod_hold;

   // end of frame decode
   wire [4:0] addr = rx[`SPX_B_AHI:`SPX_B_ALO];
   wire is_acc = rx[`SPX_B_ACC];
   wire is_wr = ~is_acc & rx[`SPX_B_AX];
   wire is_rd = ~is_acc & ~rx[`SPX_B_AX];
   wire ax_y = rx[`SPX_B_AX];
   wire spi_err = start_err | sclk_f | (edge_cnt != `SPX_FRAME_BITS)
      | ~parity_ok(rx)
      | (is_acc & (rx[`SPX_B_TOP] | (|rx[11:3])))
      | (is_rd & (|rx[7:0]));
   wire cfg_bad = is_acc & (rx[`SPX_B_CFGHI:`SPX_B_CFGLO] != i_cfg_bits);
   wire reg_bad = (is_rd & ~READABLE_MASK[addr])
      | (is_wr & (~WRITABLE_MASK[addr] | (i_config_lock_flag & (addr != `SPX_ADDR_CTL))));
   wire wr_ok = is_wr & ~spi_err & ~reg_bad;
   wire rd_ok = is_rd & ~spi_err & ~frame_mism & ~reg_bad;
   wire stat_rd = cs_rise & in_frame & rd_ok & (addr == `SPX_ADDR_STAT);
   wire internal_error_flag = otp_err | wreg_err | st_err | logic_err;
   wire ovr_x = i_ofs_ovr_x | ofsx_hold | i_modulator_ovr | mod_hold;
   wire ovr_y = i_ofs_ovr_y | ofsy_hold | i_modulator_ovr | mod_hold;
   wire acc_ovr = ax_y ? ovr_y : ovr_x;
   wire [7:0] status_byte = {st_err, mod_flag, ofsy_flag, ofsx_flag, internal_error_flag, reset_occurred, init_pending, mism_flag};
   // pad echo is judged as its bit is left: by the sclk fall it has crossed the same synchroniser as the bit
   wire rb_check = in_frame & ~cs_n_f & sclk_fall & (rb_f != o_miso);

   // response selection by fixed priority
   reg [3:0] next_code;
   reg [11:0] next_body;
   reg next_arm;
   always @* begin
      next_arm = 1'b0;
      next_body = 12'h000;
      if (spi_err) begin
         next_code = `SPX_RSP_SPI_ERR;
      end else if (frame_mism) begin
         next_code = `SPX_RSP_MISO_ERR;
      end else if (is_acc & cfg_bad) begin
         next_code = `SPX_RSP_INV_ACC;
      end else if (~is_acc & reg_bad) begin
         next_code = `SPX_RSP_INV_REG;
      end else if (is_wr) begin
         next_code = `SPX_RSP_WR_OK;
         next_body = {4'h0, rx[7:0]};
      end else if (is_rd) begin
         next_code = `SPX_RSP_RD_OK;
         next_body = {4'h0, (addr == `SPX_ADDR_STAT) ? status_byte : i_reg_rdata};
      end else if (reset_occurred) begin
         next_code = `SPX_RSP_INV_DATA;
      end else if (init_pending) begin
         next_code = `SPX_RSP_INT_ERR;
      end else if (st_err) begin
         next_code = `SPX_RSP_ST_ERR;
      end else if (internal_error_flag) begin
         next_code = `SPX_RSP_INT_ERR;
      end else begin
         next_code = `SPX_RSP_ACC_OK;
         next_body = {(acc_ovr ? `SPX_ST_OVR : `SPX_ST_NORMAL), (ax_y ? i_accel_y : i_accel_x)};
         next_arm = 1'b1;
      end
   end

   // frame engine: shift in on rising sclk, shift out on falling, readback check
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_frame <= 1'b0;
         edge_cnt <= 5'h00;
         rx <= 16'h0000;
         tx <= {`SPX_RSP_SPI_ERR, 12'h000};
         start_err <= 1'b0;
         frame_mism <= 1'b0;
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
         o_reg_addr <= 5'h00;
         o_wr_strobe <= 1'b0;
         o_wr_data <= 8'h00;
         o_arm_update <= 1'b0;
         o_arm_axis <= 1'b0;
      end else begin
         o_wr_strobe <= 1'b0;
         o_arm_update <= 1'b0;
         if (cs_fall) begin
            in_frame <= 1'b1;
            edge_cnt <= 5'h00;
            start_err <= sclk_f;
            frame_mism <= 1'b0;
            o_miso <= tx[15];
            o_miso_oe <= 1'b1;
         end else if (cs_rise & in_frame) begin
            // checks made here, answer loaded for the next frame
            in_frame <= 1'b0;
            o_miso_oe <= 1'b0;
            o_miso <= 1'b0;
            tx <= {next_code, next_body};
            o_wr_strobe <= wr_ok;
            o_wr_data <= rx[7:0];
            o_arm_update <= is_acc & next_arm;
            o_arm_axis <= ax_y;
         end else if (in_frame & ~cs_n_f) begin
            if (sclk_rise) begin
               rx <= {rx[14:0], mosi_f};
               o_reg_addr <= rx[11:7];
               if (edge_cnt != `SPX_CNT_MAX) begin
                  edge_cnt <= edge_cnt + 5'd1;
               end
            end else if (sclk_fall) begin
               if (rb_check) begin
                  frame_mism <= 1'b1;
               end
               o_miso <= tx[14];
               tx <= {tx[14:0], 1'b0};
            end
         end
      end
   end

   // sticky flags: a set wins over a clear in the same cycle
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mism_flag <= 1'b0;
         init_pending <= 1'b1;
         reset_occurred <= 1'b1;
         otp_err <= 1'b0;
         wreg_err <= 1'b0;
         st_err <= 1'b0;
         logic_err <= 1'b0;
         ofsx_flag <= 1'b0;
         ofsy_flag <= 1'b0;
         mod_flag <= 1'b0;
         ofsx_hold <= 1'b0;
         ofsy_hold <= 1'b0;
         mod_hold <= 1'b0;
         o_pcm_enable <= 1'b0;
         o_device_status_register <= 8'h00;
      end else begin
         mism_flag <= (mism_flag & ~stat_rd) | rb_check;
         init_pending <= init_pending & ~i_init_done;
         reset_occurred <= reset_occurred & ~stat_rd;
         otp_err <= otp_err | i_otp_crc_fail;
         wreg_err <= (wreg_err & ~(stat_rd & ~i_config_lock_flag)) | i_wreg_crc_fail;
         st_err <= (st_err & ~stat_rd) | i_selftest_fail;
         logic_err <= (logic_err & ~stat_rd) | i_logic_fault;
         ofsx_flag <= (ofsx_flag & ~stat_rd) | i_ofs_ovr_x;
         ofsy_flag <= (ofsy_flag & ~stat_rd) | i_ofs_ovr_y;
         mod_flag <= (mod_flag & ~stat_rd) | i_modulator_ovr;
         // one extra over-range answer after the condition goes away
         ofsx_hold <= i_ofs_ovr_x | (ofsx_hold & ~(cs_rise & in_frame & next_arm & ~ax_y));
         ofsy_hold <= i_ofs_ovr_y | (ofsy_hold & ~(cs_rise & in_frame & next_arm & ax_y));
         mod_hold <= i_modulator_ovr | (mod_hold & ~(cs_rise & in_frame & next_arm));
         o_pcm_enable <= ~(init_pending | reset_occurred);
         o_device_status_register <= status_byte;
      end
   end

endmodule // spx_exception_logic

`default_nettype wire
